// File: verilog/gpe_port.sv
// eight-pin gpio port with edge interrupts, glitch filter and axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
`include "gpe_map.svh"

// Functional notes
// - each pin edge detector uses a two-bit polarity: off, rising, falling or both edges.
// - a further detector watches a glitch filter fed by the pin that a three-bit choice names.
// - all detector flags of the port that the mask register enables are ORed into one interrupt request.
// - status bits 0 to 7 hold pin events and bit 8 the glitch filter event.
// - status bits 16 to 23 show live pin levels and bit 24 the filter output level.
// - writing one to a status flag clears it, and software must clear serviced flags.
// - a set status flag stays set until software clears it, and holds the request while its mask bit is set.
// - writes to the output data register drive only pins switched to plain io and reads return the written value.
// - set, clear and invert registers change only the output bits written with one.
// - the pin state register reads live pin levels and ignores writes.
// - a serial block using a pin as input forces that pin's output buffer off.
// - a timer block input taken from a pin forces that pin's output buffer off.
module gpe_port
  import gpe_pkg::*;
#(
  parameter int FLT_DEPTH = 3
)(
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RST,
  input  wire logic [7:0]  I_PIN_IN,
  output var  logic [7:0]  O_PIN_OUT,
  output var  logic [7:0]  O_PIN_OE,
  input  wire logic [7:0]  I_PERIPH_OUT,
  input  wire logic [7:0]  I_PERIPH_OE,
  input  wire logic [7:0]  I_SERIAL_IN,
  input  wire logic [7:0]  I_TIMER_IN,
  output var  logic        O_IRQ,
  input  wire logic        I_AWVALID,
  output var  logic        O_AWREADY,
  input  wire logic [7:0]  I_AWADDR,
  input  wire logic        I_WVALID,
  output var  logic        O_WREADY,
  input  wire logic [31:0] I_WDATA,
  input  wire logic [3:0]  I_WSTRB,
  output var  logic        O_BVALID,
  input  wire logic        I_BREADY,
  output var  logic [1:0]  O_BRESP,
  input  wire logic        I_ARVALID,
  output var  logic        O_ARREADY,
  input  wire logic [7:0]  I_ARADDR,
  output var  logic        O_RVALID,
  input  wire logic        I_RREADY,
  output var  logic [31:0] O_RDATA,
  output var  logic [1:0]  O_RRESP
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (FLT_DEPTH < 2 || FLT_DEPTH > 16)
  begin : g_bad_depth
    $error("FLT_DEPTH must lie between 2 and 16");
  end

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic edge_hit(input logic [1:0] sel, input logic cur, input logic prv);
    logic hit;
    hit = 1'b0;
    case (gpe_edge_t'(sel))
      GPE_EDGE_RISE: hit = cur & ~prv;
      GPE_EDGE_FALL: hit = ~cur & prv;
      GPE_EDGE_BOTH: hit = cur ^ prv;
      default:       hit = 1'b0;
    endcase
    return hit;
  endfunction

  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  function automatic logic [9:0] decode(input logic [7:0] addr);
    logic [9:0] hit;
    hit = 10'h000;
    hit[0] = (addr == `GPE_OFF_OUT_DATA);
    hit[1] = (addr == `GPE_OFF_OUT_SET);
    hit[2] = (addr == `GPE_OFF_OUT_CLR);
    hit[3] = (addr == `GPE_OFF_OUT_INV);
    hit[4] = (addr == `GPE_OFF_PIN_STATE);
    hit[5] = (addr == `GPE_OFF_IRQ_CFG);
    hit[6] = (addr == `GPE_OFF_IRQ_STATUS);
    hit[7] = (addr == `GPE_OFF_IRQ_MASK);
    hit[8] = (addr == `GPE_OFF_FUNC_SEL);
    hit[9] = (addr == `GPE_OFF_DRIVE_EN);
    return hit;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]           pin_s1_reg;
  logic [7:0]           pin_s2_reg;
  logic [7:0]           pin_prev_reg;
  logic [FLT_DEPTH-1:0] flt_hist_reg;
  logic                 flt_out_reg;
  logic                 flt_prev_reg;
  logic [7:0]           out_reg;
  logic [7:0]           func_reg;
  logic [7:0]           oe_reg;
  logic [31:0]          cfg_reg;
  logic [8:0]           st_reg;
  logic [8:0]           mask_reg;
  logic                 aw_got_reg;
  logic                 w_got_reg;
  logic [7:0]           awaddr_reg;
  logic [31:0]          wdata_reg;
  logic [3:0]           wstrb_reg;
  gpe_irq_cfg_t         cfg_view;

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  wire        aw_hs    = I_AWVALID & O_AWREADY;
  wire        w_hs     = I_WVALID & O_WREADY;
  wire        aw_have  = aw_got_reg | aw_hs;
  wire        w_have   = w_got_reg | w_hs;
  // address and data may arrive in either order; the response waits for both
  wire        do_wr    = aw_have & w_have & ~O_BVALID;
  wire [7:0]  wr_addr  = aw_got_reg ? awaddr_reg : I_AWADDR;
  wire [31:0] wr_data  = w_got_reg ? wdata_reg : I_WDATA;
  wire [3:0]  wr_strb  = w_got_reg ? wstrb_reg : I_WSTRB;
  wire [9:0]  wr_hit   = decode(wr_addr);
  wire        wr_ok    = |wr_hit;
  wire [31:0] wr_lane  = lane_mask(wr_strb);
  wire [31:0] wr_bits  = wr_data & wr_lane;
  wire        aw_next  = aw_have & ~do_wr;
  wire        w_next   = w_have & ~do_wr;
  wire        bv_next  = do_wr | (O_BVALID & ~I_BREADY);

  wire wr_is_dr  = do_wr & wr_hit[0];
  wire wr_is_set = do_wr & wr_hit[1];
  wire wr_is_clr = do_wr & wr_hit[2];
  wire wr_is_inv = do_wr & wr_hit[3];
  wire wr_is_ps  = do_wr & wr_hit[4];
  wire wr_is_cfg = do_wr & wr_hit[5];
  wire wr_is_st  = do_wr & wr_hit[6];
  wire wr_is_msk = do_wr & wr_hit[7];
  wire wr_is_fn  = do_wr & wr_hit[8];
  wire wr_is_oe  = do_wr & wr_hit[9];

  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST)
    begin
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
      O_AWREADY  <= 1'b0;
      O_WREADY   <= 1'b0;
      O_BVALID   <= 1'b0;
      O_BRESP    <= `GPE_RESP_OKAY;
      awaddr_reg <= 8'h00;
      wdata_reg  <= 32'h0000_0000;
      wstrb_reg  <= 4'h0;
    end
    else
    begin
      aw_got_reg <= aw_next;
      w_got_reg  <= w_next;
      O_AWREADY  <= ~aw_next & ~bv_next;
      O_WREADY   <= ~w_next & ~bv_next;
      O_BVALID   <= bv_next;
      if (do_wr)
        O_BRESP <= wr_ok ? `GPE_RESP_OKAY : `GPE_RESP_SLVERR;
      if (aw_hs)
        awaddr_reg <= I_AWADDR;
      if (w_hs)
      begin
        wdata_reg <= I_WDATA;
        wstrb_reg <= I_WSTRB;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin sampling and glitch filter
  // ----------------------------------------------------------------
  assign cfg_view = cfg_reg;
  wire [2:0] flt_pin = cfg_view.filter_pin_choice;
  wire       flt_in  = pin_s2_reg[flt_pin];
  wire       flt_hi  = &flt_hist_reg;
  wire       flt_lo  = ~|flt_hist_reg;
  // a level must hold for FLT_DEPTH samples before the filter output follows
  wire       flt_next = flt_hi ? 1'b1 : (flt_lo ? 1'b0 : flt_out_reg);

  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST)
    begin
      pin_s1_reg   <= 8'h00;
      pin_s2_reg   <= 8'h00;
      pin_prev_reg <= 8'h00;
      flt_hist_reg <= '0;
      flt_out_reg  <= 1'b0;
      flt_prev_reg <= 1'b0;
    end
    else
    begin
      pin_s1_reg   <= I_PIN_IN;
      pin_s2_reg   <= pin_s1_reg;
      pin_prev_reg <= pin_s2_reg;
      flt_hist_reg <= {flt_hist_reg[FLT_DEPTH-2:0], flt_in};
      flt_out_reg  <= flt_next;
      flt_prev_reg <= flt_out_reg;
    end
  end

  // ----------------------------------------------------------------
  // edge detectors and interrupt status
  // ----------------------------------------------------------------
  logic [8:0] ev_all;
  for (genvar g = 0; g < 8; g++)
  begin : g_edge
    assign ev_all[g] = edge_hit(cfg_reg[2*g +: 2], pin_s2_reg[g], pin_prev_reg[g]);
  end
  assign ev_all[`GPE_ST_FLT_EVT] = edge_hit(cfg_view.flt_edge,
                                            flt_out_reg, flt_prev_reg);

  wire [8:0] st_clr  = wr_is_st ? wr_bits[8:0] : 9'h000;
  // an event in the clearing cycle survives the clear
  wire [8:0] st_next = (st_reg & ~st_clr) | ev_all;
  wire [8:0] mask_next = wr_is_msk ? ((mask_reg & ~wr_lane[8:0]) | wr_bits[8:0]) : mask_reg;
  // gate with the new mask so the request never lags a mask write by a cycle
  wire       irq_next = |(st_next & mask_next);

  // ----------------------------------------------------------------
  // output data and pin drive
  // ----------------------------------------------------------------
  wire [7:0] lo_bits = wr_bits[7:0];
  wire [7:0] out_dr  = (out_reg & ~wr_lane[7:0]) | lo_bits;
  wire [7:0] out_next = wr_is_dr  ? out_dr :
                        wr_is_set ? (out_reg | lo_bits) :
                        wr_is_clr ? (out_reg & ~lo_bits) :
                        wr_is_inv ? (out_reg ^ lo_bits) : out_reg;
  // firmware drives only pins switched to plain io; others belong to peripherals
  wire [7:0] pin_val = (func_reg & out_reg) | (~func_reg & I_PERIPH_OUT);
  wire [7:0] pin_en  = (func_reg & oe_reg) | (~func_reg & I_PERIPH_OE);
  wire [7:0] pin_off = I_SERIAL_IN | I_TIMER_IN;

  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST)
    begin
      out_reg   <= `GPE_RST_OUT_DATA;
      func_reg  <= `GPE_RST_FUNC_SEL;
      oe_reg    <= `GPE_RST_DRIVE_EN;
      cfg_reg   <= `GPE_RST_IRQ_CFG;
      st_reg    <= 9'h000;
      mask_reg  <= `GPE_RST_IRQ_MASK;
      O_IRQ     <= 1'b0;
      O_PIN_OUT <= 8'h00;
      O_PIN_OE  <= 8'h00;
    end
    else
    begin
      out_reg   <= out_next;
      st_reg    <= st_next;
      O_IRQ     <= irq_next;
      O_PIN_OUT <= pin_val;
      O_PIN_OE  <= pin_en & ~pin_off;
      if (wr_is_fn)
        func_reg <= (func_reg & ~wr_lane[7:0]) | lo_bits;
      if (wr_is_oe)
        oe_reg <= (oe_reg & ~wr_lane[7:0]) | lo_bits;
      if (wr_is_cfg)
        cfg_reg <= ((cfg_reg & ~wr_lane) | wr_bits) & `GPE_CFG_MASK;
      mask_reg  <= mask_next;
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  wire        ar_hs   = I_ARVALID & O_ARREADY;
  wire        rv_next = ar_hs | (O_RVALID & ~I_RREADY);
  wire [9:0]  rd_hit  = decode(I_ARADDR);
  wire        rd_ok   = |rd_hit;
  // status read has no side effect, so a read racing an edge loses nothing here
  wire [31:0] rd_st   = {7'h00, flt_out_reg, pin_s2_reg, 7'h00, st_reg};
  wire [31:0] rd_data = rd_hit[0] ? {24'h000000, out_reg} :
                        rd_hit[4] ? {24'h000000, pin_s2_reg} :
                        rd_hit[5] ? cfg_reg :
                        rd_hit[6] ? rd_st :
                        rd_hit[7] ? {23'h000000, mask_reg} :
                        rd_hit[8] ? {24'h000000, func_reg} :
                        rd_hit[9] ? {24'h000000, oe_reg} : 32'h0000_0000;

  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST)
    begin
      O_ARREADY <= 1'b0;
      O_RVALID  <= 1'b0;
      O_RDATA   <= 32'h0000_0000;
      O_RRESP   <= `GPE_RESP_OKAY;
    end
    else
    begin
      O_ARREADY <= ~rv_next;
      O_RVALID  <= rv_next;
      if (ar_hs)
      begin
        O_RDATA <= rd_data;
        O_RRESP <= rd_ok ? `GPE_RESP_OKAY : `GPE_RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);

  wire rd_is_st = ar_hs & rd_hit[6];
  wire rd_is_dr = ar_hs & rd_hit[0];

  a_rise_sets_flag: assert property (
    (cfg_reg[15:14] == 2'h1 && pin_s2_reg[7] && !pin_prev_reg[7]) |=> st_reg[7])
    else $error("rising edge did not set pin 7 flag");

  a_edge_off_quiet: assert property (
    (cfg_reg[1:0] == 2'h0 && !st_reg[0]) |=> !st_reg[0])
    else $error("disabled detector set pin 0 flag");

  a_filter_flag_set: assert property (
    (cfg_view.flt_edge[0] && flt_out_reg && !flt_prev_reg) |=> st_reg[8])
    else $error("filter rising edge did not set bit 8");

  a_irq_or_mask: assert property (
    O_IRQ == |(st_reg & mask_reg))
    else $error("interrupt output differs from masked status");

  a_status_sticky: assert property (
    ##1 (($past(st_reg) & ~$past(st_clr) & ~st_reg) == 9'h000))
    else $error("status flag dropped without a clear");

  a_w1c_clears: assert property (
    ##1 ((st_reg & $past(st_clr) & ~$past(ev_all)) == 9'h000))
    else $error("write one did not clear a status flag");

  a_set_beats_clear: assert property (
    ##1 (($past(ev_all) & ~st_reg) == 9'h000))
    else $error("event lost in clearing cycle");

  a_edge_from_sample: assert property (
    ##1 ((st_reg & ~$past(st_reg) & ~{1'b1, $past(pin_s2_reg) ^ $past(pin_prev_reg)}) == 9'h000))
    else $error("pin flag set without a sampled change");

  a_status_levels: assert property (
    rd_is_st |=> (O_RDATA[23:16] == $past(pin_s2_reg)) && O_RVALID)
    else $error("status read lacks pin levels");

  a_data_readback: assert property (
    rd_is_dr |=> O_RDATA[7:0] == $past(out_reg))
    else $error("output data read differs from written value");

  a_set_only_ones: assert property (
    (wr_is_set && wr_strb[0]) |=> out_reg == ($past(out_reg) | $past(wr_data[7:0])))
    else $error("set register changed bits written zero");

  a_ps_ignores_wr: assert property (
    wr_is_ps |=> $stable(out_reg) && $stable(oe_reg) && $stable(cfg_reg))
    else $error("pin state write changed a register");

  a_serial_off: assert property (
    ##1 ((O_PIN_OE & $past(I_SERIAL_IN)) == 8'h00))
    else $error("serial input pin still driven");

  a_timer_off: assert property (
    ##1 ((O_PIN_OE & $past(I_TIMER_IN)) == 8'h00))
    else $error("timer input pin still driven");

  a_wr_response: assert property (
    do_wr |=> O_BVALID)
    else $error("write taken without response");

  c_filter_event: cover property (ev_all[8]);
  c_irq_cycle:    cover property (O_IRQ ##[1:40] !O_IRQ);
  c_set_clear:    cover property (st_clr[0] && ev_all[0]);
  c_read_done:    cover property (O_RVALID && I_RREADY);

endmodule

`default_nettype wire

// File: verilog/gpe_map.svh
// register offsets, field positions and reset values of the gpio port block
`ifndef GPE_MAP_SVH
`define GPE_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define GPE_OFF_OUT_DATA   8'h00
`define GPE_OFF_OUT_SET    8'h04
`define GPE_OFF_OUT_CLR    8'h08
`define GPE_OFF_OUT_INV    8'h0C
`define GPE_OFF_PIN_STATE  8'h10
`define GPE_OFF_IRQ_CFG    8'h14
`define GPE_OFF_IRQ_STATUS 8'h18
`define GPE_OFF_IRQ_MASK   8'h1C
`define GPE_OFF_FUNC_SEL   8'h20
`define GPE_OFF_DRIVE_EN   8'h24

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define GPE_ST_FLT_EVT     8
`define GPE_ST_PIN_LSB     16
`define GPE_ST_FLT_LVL     24
`define GPE_CFG_MASK       32'h001F_FFFF

// ----------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------
`define GPE_RST_OUT_DATA   8'h00
`define GPE_RST_IRQ_CFG    32'h0000_0000
`define GPE_RST_IRQ_MASK   9'h000
`define GPE_RST_FUNC_SEL   8'h00
`define GPE_RST_DRIVE_EN   8'h00
`define GPE_RESP_OKAY      2'h0
`define GPE_RESP_SLVERR    2'h2

`endif

// File: verilog/gpe_pkg.sv
// types shared by the gpio port block
`default_nettype none
package gpe_pkg;

  // ----------------------------------------------------------------
  // edge detector trigger polarity
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    GPE_EDGE_OFF  = 2'h0,
    GPE_EDGE_RISE = 2'h1,
    GPE_EDGE_FALL = 2'h2,
    GPE_EDGE_BOTH = 2'h3
  } gpe_edge_t;

  // ----------------------------------------------------------------
  // port_irq_config layout
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [10:0] rsvd;
    logic [2:0]  filter_pin_choice;
    logic [1:0]  flt_edge;
    logic [15:0] pin_edge;
  } gpe_irq_cfg_t;

endpackage

`default_nettype wire

// File: testbench/gpe_pin_model.sv
// pin pads of the port: port drive, an outside driver and pull-ups
`timescale 1ns/1ps
`default_nettype none
module gpe_pin_model (
  input  wire logic [7:0] i_out,
  input  wire logic [7:0] i_oe,
  input  wire logic [7:0] i_ext_val,
  input  wire logic [7:0] i_ext_oe,
  output var  logic [7:0] o_level
);
  // ----------------------------------------------------------------
  // pad resolution
  // ----------------------------------------------------------------
  // an undriven pin goes to its pull-up, never keeps the last driven value
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      o_level[i] = i_oe[i] ? i_out[i] : (i_ext_oe[i] ? i_ext_val[i] : 1'b1);
    end
  end
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
// self-checking bench for the gpio port block
`timescale 1ns/1ps
`default_nettype none
`include "gpe_map.svh"
module tb_top
  import gpe_pkg::*;
;
  logic         clk;
  logic         rst;
  logic [7:0]   ext_val;
  logic [7:0]   ext_oe;
  logic [7:0]   pin_lvl;
  logic [7:0]   pin_out;
  logic [7:0]   pin_oe;
  logic [7:0]   periph_out;
  logic [7:0]   periph_oe;
  logic [7:0]   serial_in;
  logic [7:0]   timer_in;
  logic         irq;
  logic         aw_v;
  logic         w_v;
  logic         b_r;
  logic         ar_v;
  logic         r_r;
  logic         aw_rdy;
  logic         w_rdy;
  logic         b_v;
  logic         ar_rdy;
  logic         r_v;
  logic [7:0]   aw_a;
  logic [7:0]   ar_a;
  logic [31:0]  w_d;
  logic [31:0]  r_d;
  logic [3:0]   w_s;
  logic [1:0]   b_resp;
  logic [1:0]   r_resp;
  logic [31:0]  rd_v;
  logic [1:0]   rsp;
  gpe_irq_cfg_t cfg;
  int           fail_count;
  int           comparisons;
  int           cycles;

  gpe_port #(.FLT_DEPTH(3)) dut (
    .I_CORE_CLK(clk), .I_RST(rst), .I_PIN_IN(pin_lvl), .O_PIN_OUT(pin_out),
    .O_PIN_OE(pin_oe), .I_PERIPH_OUT(periph_out), .I_PERIPH_OE(periph_oe),
    .I_SERIAL_IN(serial_in), .I_TIMER_IN(timer_in), .O_IRQ(irq),
    .I_AWVALID(aw_v), .O_AWREADY(aw_rdy), .I_AWADDR(aw_a), .I_WVALID(w_v),
    .O_WREADY(w_rdy), .I_WDATA(w_d), .I_WSTRB(w_s), .O_BVALID(b_v),
    .I_BREADY(b_r), .O_BRESP(b_resp), .I_ARVALID(ar_v), .O_ARREADY(ar_rdy),
    .I_ARADDR(ar_a), .O_RVALID(r_v), .I_RREADY(r_r), .O_RDATA(r_d), .O_RRESP(r_resp)
  );

  gpe_pin_model pads (
    .i_out(pin_out), .i_oe(pin_oe), .i_ext_val(ext_val), .i_ext_oe(ext_oe),
    .o_level(pin_lvl)
  );

  always #50 clk = ~clk;

  // ----------------------------------------------------------------
  // bus tasks and comparison
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error at %0t ns: expected %h got %h", $time, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    aw_v <= 1'b1;
    w_v  <= 1'b1;
    b_r  <= 1'b1;
    aw_a <= a;
    w_d  <= d;
    forever
    begin
      @(posedge clk);
      if (aw_v && aw_rdy) aw_v <= 1'b0;
      if (w_v && w_rdy) w_v <= 1'b0;
      if (b_v)
      begin
        r = b_resp;
        b_r <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    ar_v <= 1'b1;
    r_r  <= 1'b1;
    ar_a <= a;
    forever
    begin
      @(posedge clk);
      if (ar_v && ar_rdy) ar_v <= 1'b0;
      if (r_v)
      begin
        d = r_d;
        r = r_resp;
        r_r <= 1'b0;
        break;
      end
    end
  endtask

  // outside pins change, then the synchroniser and filter get time to settle
  task automatic drive(input logic [7:0] v);
    @(posedge clk);
    ext_val <= v;
    tick(10);
  endtask

  task automatic conclude();
    if (fail_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // a hang is cut short far beyond the few hundred cycles the tests need
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0; rst = 1'b1; ext_val = 8'h30; ext_oe = 8'hF0;
    periph_out = 8'h00; periph_oe = 8'h00; serial_in = 8'h00; timer_in = 8'h00;
    aw_v = 1'b0; w_v = 1'b0; b_r = 1'b0; ar_v = 1'b0; r_r = 1'b0;
    aw_a = 8'h00; ar_a = 8'h00; w_d = 32'h0; w_s = 4'hF; cfg = '0;
    fail_count = 0; comparisons = 0; cycles = 0;
    tick(12);
    rst <= 1'b0;
    rd(`GPE_OFF_OUT_DATA, rd_v, rsp); chk({24'h0, `GPE_RST_OUT_DATA}, rd_v);
    rd(`GPE_OFF_IRQ_CFG, rd_v, rsp); chk(`GPE_RST_IRQ_CFG, rd_v);
    rd(8'h30, rd_v, rsp); chk(32'h0, rd_v); chk({30'h0, `GPE_RESP_SLVERR}, {30'h0, rsp});
    wr(8'h30, 32'hFFFF_FFFF, rsp); chk({30'h0, `GPE_RESP_SLVERR}, {30'h0, rsp});
    // output data and its bitwise set, clear and invert
    wr(`GPE_OFF_OUT_DATA, 32'hA5, rsp); rd(`GPE_OFF_OUT_DATA, rd_v, rsp); chk(32'hA5, rd_v);
    wr(`GPE_OFF_OUT_SET, 32'h0F, rsp); rd(`GPE_OFF_OUT_DATA, rd_v, rsp); chk(32'hAF, rd_v);
    wr(`GPE_OFF_OUT_CLR, 32'h81, rsp); rd(`GPE_OFF_OUT_DATA, rd_v, rsp); chk(32'h2E, rd_v);
    wr(`GPE_OFF_OUT_INV, 32'hFF, rsp); rd(`GPE_OFF_OUT_DATA, rd_v, rsp); chk(32'hD1, rd_v);
    wr(`GPE_OFF_PIN_STATE, 32'hFF, rsp);
    rd(`GPE_OFF_OUT_DATA, rd_v, rsp); chk(32'hD1, rd_v);
    // firmware drives the low nibble, the outside world the high one
    wr(`GPE_OFF_FUNC_SEL, 32'hFF, rsp);
    wr(`GPE_OFF_DRIVE_EN, 32'h0F, rsp);
    tick(10);
    chk(32'h0F, {24'h0, pin_oe});
    chk(32'hD1, {24'h0, pin_out});
    rd(`GPE_OFF_PIN_STATE, rd_v, rsp); chk(32'h31, rd_v);
    rd(`GPE_OFF_IRQ_STATUS, rd_v, rsp); chk(32'h0131_0000, rd_v);
    serial_in <= 8'h01; tick(3); chk(32'h0E, {24'h0, pin_oe});
    timer_in <= 8'h02; tick(3); chk(32'h0C, {24'h0, pin_oe});
    serial_in <= 8'h00; timer_in <= 8'h00; periph_oe <= 8'h03; periph_out <= 8'h02;
    wr(`GPE_OFF_FUNC_SEL, 32'h00, rsp);
    tick(10);
    chk(32'h03, {24'h0, pin_oe});
    rd(`GPE_OFF_PIN_STATE, rd_v, rsp); chk(32'h3E, rd_v);
    wr(`GPE_OFF_FUNC_SEL, 32'hFF, rsp);
    // every trigger polarity on pin 7
    wr(`GPE_OFF_IRQ_MASK, 32'h080, rsp);
    for (int m = 0; m < 4; m++)
    begin
      cfg = '0;
      cfg.pin_edge[15:14] = m[1:0];
      wr(`GPE_OFF_IRQ_CFG, cfg, rsp);
      wr(`GPE_OFF_IRQ_STATUS, 32'h1FF, rsp);
      drive(8'hB0);
      rd(`GPE_OFF_IRQ_STATUS, rd_v, rsp); chk({8'h01, 8'hB1, 8'h00, m[0], 7'h0}, rd_v);
      chk({31'h0, m[0]}, {31'h0, irq});
      tick(20); chk({31'h0, m[0]}, {31'h0, irq});
      wr(`GPE_OFF_IRQ_STATUS, 32'h080, rsp);
      tick(3); chk(32'h0, {31'h0, irq});
      drive(8'h30);
      rd(`GPE_OFF_IRQ_STATUS, rd_v, rsp); chk({8'h01, 8'h31, 8'h00, m[1], 7'h0}, rd_v);
      chk({31'h0, m[1]}, {31'h0, irq});
      wr(`GPE_OFF_IRQ_STATUS, 32'h080, rsp);
    end
    // glitch filter on pin 6: a one-cycle pulse is swallowed, a held level passes
    cfg = '0;
    cfg.filter_pin_choice = 3'h6;
    cfg.flt_edge = GPE_EDGE_RISE;
    wr(`GPE_OFF_IRQ_CFG, cfg, rsp);
    wr(`GPE_OFF_IRQ_MASK, 32'h100, rsp);
    tick(10);
    wr(`GPE_OFF_IRQ_STATUS, 32'h1FF, rsp);
    @(posedge clk); ext_val <= 8'h70;
    @(posedge clk); ext_val <= 8'h30;
    tick(10);
    rd(`GPE_OFF_IRQ_STATUS, rd_v, rsp); chk(32'h0031_0000, rd_v);
    chk(32'h0, {31'h0, irq});
    drive(8'h70);
    rd(`GPE_OFF_IRQ_STATUS, rd_v, rsp); chk(32'h0171_0100, rd_v);
    chk(32'h1, {31'h0, irq});
    wr(`GPE_OFF_IRQ_MASK, 32'h000, rsp);
    tick(3); chk(32'h0, {31'h0, irq});
    // each filter pin choice, seen through the filter level with pins at 0x71
    for (int k = 0; k < 8; k++)
    begin
      cfg = '0;
      cfg.filter_pin_choice = k[2:0];
      wr(`GPE_OFF_IRQ_CFG, cfg, rsp);
      tick(10);
      rd(`GPE_OFF_IRQ_STATUS, rd_v, rsp);
      chk(32'((8'h71 >> k) & 8'h01), {31'h0, rd_v[24]});
    end
    conclude();
  end
endmodule
`default_nettype wire
